/* rtl/parallel_port_decode_and_mode.sv */
// Host-side parallel printer port: I/O window decode, data/control/status, interrupt routing.
// Assumes APB master; switch and jumper pins are static levels from outside the clock domain.
// Behaviour
// R1: Claim four addresses; low bits select location.
// R2: Compare A8..A2 to switches; A9 must be one.
// R3: Closed switch wants zero, open wants one.
// R4: Switch eight closed enables, open ignores cycles.
// R5: Drive only header-selected interrupt line, else none.
// R6: Installer removes interrupt jumper on disabled port.
// R7: Normal mode sole driver; shared mode drives only requests.
// R8: Normal setting: data always driven; bidirectional: software.
// R9: Control direction bit set turns drivers off.
// R10: Software changes direction bit by read-modify-write.
// R11: Not all control bits read back.
// R12: Reset gives output-only port, drivers on.
// R13: Edge-raised interrupt with readable pending status.
// R14: Data write latches; read returns line levels (here only with drivers off; with drivers on the read returns the latched byte).
// R15: Normal setting ignores direction bit entirely.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module parallel_port_decode_and_mode (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [12:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [parport_pkg::SW_ADDR_W-1:0] sw_addr_closed,
   input  wire logic                          sw_enable_closed,
   input  wire logic [parport_pkg::IRQ_LINES-1:0] irq_line_header,
   input  wire logic                          irq_shared_sel,
   input  wire logic                          port_bidir_sel,
   input  wire logic [7:0]                    pd_in,
   output logic      [7:0]                    pd_out,
   output logic                               pd_oe,
   input  wire logic                          busy,
   input  wire logic                          ack_n,
   input  wire logic                          paper_out,
   input  wire logic                          selected,
   input  wire logic                          fault_n,
   output logic      [3:0]                    ctrl_pins,
   output logic      [parport_pkg::IRQ_LINES-1:0] irq_line_out,
   output logic      [parport_pkg::IRQ_LINES-1:0] irq_line_oe,
   output logic                               irq
);
   import parport_pkg::*;

   typedef struct packed {
      logic [7:0]           dat;
      logic [5:0]           ctl;
      logic                 ists;
      logic                 imask;
      logic                 ack_prev;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic                 data_oe;
      logic                 irq;
      logic [IRQ_LINES-1:0] irq_out;
      logic [IRQ_LINES-1:0] irq_oe;
   } state_t;

   localparam state_t STATE_RST = '{
      // Edge memory starts low like the synchroniser, so no false edge follows reset
      dat: DATA_RST, ctl: CTRL_RST, ists: 1'b0, imask: MASK_RST, ack_prev: 1'b0,
      prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0, data_oe: 1'b1,
      irq: 1'b0, irq_out: '0, irq_oe: '0};

   state_t s_r;
   state_t s_nxt;

   logic [SYNC_W-1:0] raw_pins;
   logic [SYNC_W-1:0] sync_pins;
   logic [SW_ADDR_W-1:0] sw_closed_s;
   logic                 en_s;
   logic [IRQ_LINES-1:0] hdr_s;
   logic                 shared_s;
   logic                 bidir_s;
   logic [7:0]           pd_in_s;
   logic [4:0]           stat_s;

   // Jumpers and switches are asynchronous pins too, so they share the synchroniser
   assign raw_pins = {sw_addr_closed, sw_enable_closed, irq_line_header, irq_shared_sel,
                      port_bidir_sel, pd_in, busy, ack_n, paper_out, selected, fault_n};

   pin_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pins   (raw_pins),
      .pins_s (sync_pins)
   );

   assign {sw_closed_s, en_s, hdr_s, shared_s, bidir_s, pd_in_s, stat_s} = sync_pins;

   function automatic logic port_match(input logic [12:0] a, input logic en,
                                       input logic [SW_ADDR_W-1:0] closed);
      logic [IO_ADDR_W-1:0] io;
      io = a[11:2];
      port_match = en && !a[12] && io[9] && (io[8:2] == ~closed); // see R2 see R3 see R4
   endfunction

   logic io_hit;
   logic own_hit;
   logic setup_ph;
   logic acc_wr;
   logic ack_fall;
   logic [1:0] loc;

   always_comb begin
      s_nxt    = s_r;
      io_hit   = port_match(paddr, en_s, sw_closed_s);
      own_hit  = (paddr == OWN_IRQ_STATUS) || (paddr == OWN_IRQ_MASK);
      loc      = paddr[3:2]; // see R1
      setup_ph = psel && !penable;
      acc_wr   = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
      ack_fall = s_r.ack_prev && !stat_s[3];
      s_nxt.ack_prev = stat_s[3];
      s_nxt.pready   = 1'b0;
      s_nxt.pslverr  = 1'b0;

      if (setup_ph) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = !(io_hit || own_hit); // see R4
         s_nxt.prdata  = 32'h0000_0000;
         if (io_hit) begin
            if (loc == LOC_DATA) begin
               s_nxt.prdata[7:0] = s_r.data_oe ? s_r.dat : pd_in_s; // see R14
            end else if (loc == LOC_STATUS) begin
               s_nxt.prdata[7:0] = {stat_s, s_r.ists, 2'b00}; // see R13
            end else if (loc == LOC_CTRL) begin
               // Upper two bits have no storage and read zero
               s_nxt.prdata[7:0] = {2'b00, s_r.ctl}; // see R11
            end
         end else if (paddr == OWN_IRQ_STATUS) begin
            s_nxt.prdata[0] = s_r.ists;
         end else if (paddr == OWN_IRQ_MASK) begin
            s_nxt.prdata[0] = s_r.imask;
         end
      end

      if (acc_wr) begin
         if (io_hit) begin
            if (loc == LOC_DATA) begin
               s_nxt.dat = pwdata[7:0]; // see R14
            end else if (loc == LOC_CTRL) begin
               s_nxt.ctl = pwdata[5:0]; // see R9 see R11
            end
         end else if (paddr == OWN_IRQ_STATUS) begin
            if (pwdata[0]) begin
               s_nxt.ists = 1'b0;
            end
         end else if (paddr == OWN_IRQ_MASK) begin
            s_nxt.imask = pwdata[0];
         end
      end

      // Set after clear so a coincident acknowledge edge is not lost
      if (ack_fall && s_r.ctl[CTRL_IRQ_EN_BIT]) begin
         s_nxt.ists = 1'b1; // see R13
      end

      // Direction bit only matters with the bidirectional jumper
      s_nxt.data_oe = !(bidir_s && s_nxt.ctl[CTRL_DIR_BIT]); // see R8 see R9 see R15
      s_nxt.irq     = s_nxt.ists && s_nxt.imask;

      for (int i = 0; i < IRQ_LINES; i++) begin
         if (shared_s) begin
            // Shared lines are released while idle so other adapters can pull them
            s_nxt.irq_oe[i]  = hdr_s[i] && s_nxt.irq; // see R7
            s_nxt.irq_out[i] = hdr_s[i];
         end else begin
            s_nxt.irq_oe[i]  = hdr_s[i]; // see R5 see R7
            s_nxt.irq_out[i] = hdr_s[i] && s_nxt.irq; // see R13
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= STATE_RST; // see R12
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata       = s_r.prdata;
   assign pready       = s_r.pready;
   assign pslverr      = s_r.pslverr;
   assign pd_out       = s_r.dat;
   assign pd_oe        = s_r.data_oe;
   assign ctrl_pins    = s_r.ctl[3:0];
   assign irq_line_out = s_r.irq_out;
   assign irq_line_oe  = s_r.irq_oe;
   assign irq          = s_r.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_window_miss;
      (setup_ph && !paddr[12] && !io_hit) |=> (pready && pslverr);
   endproperty
   a_window_miss: assert property (p_window_miss) // see R1 see R3
      else $error("unmatched I/O address answered without error");

   property p_a9_low;
      (setup_ph && !paddr[12] && !paddr[11]) |=> pslverr;
   endproperty
   a_a9_low: assert property (p_a9_low) // see R2
      else $error("address with A9 low was claimed");

   property p_disabled;
      (setup_ph && !en_s && !paddr[12]) |=> (pslverr ##1 !pready);
   endproperty
   a_disabled: assert property (p_disabled) // see R4
      else $error("disabled port claimed an I/O cycle");

   property p_no_header;
      ($past(hdr_s) == '0) |-> (irq_line_oe == '0);
   endproperty
   a_no_header: assert property (p_no_header) // see R5
      else $error("interrupt line driven with empty header");

   property p_normal_irq;
      !$past(shared_s) |-> (irq_line_oe == $past(hdr_s));
   endproperty
   a_normal_irq: assert property (p_normal_irq) // see R7
      else $error("normal interrupt mode not sole driver of selected line");

   property p_normal_port;
      !$past(bidir_s) |-> pd_oe;
   endproperty
   a_normal_port: assert property (p_normal_port) // see R8 see R15
      else $error("data drivers off in normal port setting");

   property p_dir_bit;
      (acc_wr && io_hit && loc == LOC_CTRL && pwdata[CTRL_DIR_BIT] && bidir_s)
         |=> !pd_oe;
   endproperty
   a_dir_bit: assert property (p_dir_bit) // see R9
      else $error("direction bit set but data drivers stay on");

   property p_reset_out;
      @(posedge clk) disable iff (1'b0) !rst_n |=> (pd_oe && !irq);
   endproperty
   a_reset_out: assert property (p_reset_out) // see R12
      else $error("port not output-only after reset");

   property p_pending;
      (ack_fall && s_r.ctl[CTRL_IRQ_EN_BIT]) |=> (s_r.ists && (irq == s_r.imask));
   endproperty
   a_pending: assert property (p_pending) // see R13
      else $error("acknowledge edge did not set pending status");

   property p_data_latch;
      (acc_wr && io_hit && loc == LOC_DATA) |=> (pd_out == $past(pwdata[7:0]));
   endproperty
   a_data_latch: assert property (p_data_latch) // see R14
      else $error("data write not latched to data lines");

   property p_window_hit;
      (setup_ph && io_hit) |=> (pready && !pslverr);
   endproperty
   a_window_hit: assert property (p_window_hit) // see R1 see R4
      else $error("matched I/O address not answered cleanly");

   property p_spare_loc;
      (setup_ph && io_hit && loc == LOC_SPARE) |=> (prdata == 32'h0000_0000);
   endproperty
   a_spare_loc: assert property (p_spare_loc) // see R1
      else $error("fourth location returned data");

   property p_ctrl_upper;
      (setup_ph && io_hit && loc == LOC_CTRL) |=> (prdata[7:6] == 2'b00);
   endproperty
   a_ctrl_upper: assert property (p_ctrl_upper) // see R11
      else $error("control bits without storage read back");

   property p_data_read;
      (setup_ph && io_hit && loc == LOC_DATA && pd_oe) |=> (prdata[7:0] == pd_out);
   endproperty
   a_data_read: assert property (p_data_read) // see R14
      else $error("data read in output mode not the latched byte");

   property p_no_level_set;
      (!s_r.ists && !(ack_fall && s_r.ctl[CTRL_IRQ_EN_BIT])) |=> !s_r.ists;
   endproperty
   a_no_level_set: assert property (p_no_level_set) // see R13
      else $error("pending status set without an acknowledge edge");

   property p_pend_clear;
      (acc_wr && paddr == OWN_IRQ_STATUS && pwdata[0]
         && !(ack_fall && s_r.ctl[CTRL_IRQ_EN_BIT])) |=> !s_r.ists;
   endproperty
   a_pend_clear: assert property (p_pend_clear) // see R13
      else $error("pending status not cleared by write of one");

   property p_shared_idle;
      ($past(shared_s) && !irq) |-> (irq_line_oe == '0);
   endproperty
   a_shared_idle: assert property (p_shared_idle) // see R7
      else $error("shared interrupt line driven while idle");

   property p_reset_regs;
      @(posedge clk) disable iff (1'b0) !rst_n |=> (ctrl_pins == 4'h0 && irq_line_oe == '0);
   endproperty
   a_reset_regs: assert property (p_reset_regs) // see R12
      else $error("control or interrupt outputs not cleared by reset");
endmodule

/* rtl/parport_pkg.sv */
// Constants shared by the parallel port decode block and its pin synchroniser.
// Assumes APB word addressing: I/O location n sits at byte address 4*n.
package parport_pkg;
   localparam int IO_ADDR_W = 10;
   localparam int SW_ADDR_W = 7;
   localparam int IRQ_LINES = 5;
   localparam logic [1:0] LOC_DATA   = 2'h0;
   localparam logic [1:0] LOC_STATUS = 2'h1;
   localparam logic [1:0] LOC_CTRL   = 2'h2;
   localparam logic [1:0] LOC_SPARE  = 2'h3;
   localparam logic [12:0] OWN_IRQ_STATUS = 13'h1000;
   localparam logic [12:0] OWN_IRQ_MASK   = 13'h1004;
   localparam int CTRL_DIR_BIT    = 5;
   localparam int CTRL_IRQ_EN_BIT = 4;
   localparam int STATUS_PEND_BIT = 2;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic       MASK_RST = 1'h0;
   localparam int SYNC_W = 28;
endpackage

/* rtl/pin_sync.sv */
// Two-stage synchroniser for a vector of slow pin levels.
// Assumes each bit is a level that holds for several clocks.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pins,
   output logic      [W-1:0] pins_s
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         pins_s <= '0;
      end else begin
         meta_r <= pins;
         pins_s <= meta_r;
      end
   end
endmodule

/* bench/printer_model.sv */
// Printer-side model: shares the data wire and drives the status pins.
// Assumes the port drives the data lines only while pd_oe is high.
`timescale 1ns/10ps
module printer_model (
   input  wire logic       clk,
   input  wire logic [7:0] pd_out,
   input  wire logic       pd_oe,
   input  wire logic [7:0] ext_byte,
   input  wire logic       ack_req,
   output logic      [7:0] pd_in,
   output logic            ack_n,
   output logic            busy,
   output logic            paper_out,
   output logic            selected,
   output logic            fault_n
);
   // Wire level: the port wins while enabled, else the printer byte
   assign pd_in = pd_oe ? pd_out : ext_byte;
   // Acknowledge is a level held as long as the bench asks
   always_ff @(posedge clk) begin
      ack_n <= !ack_req;
   end
   assign busy = 1'b0;
   assign paper_out = 1'b0;
   assign selected = 1'b1;
   assign fault_n = 1'b1;
endmodule

/* bench/tb_parallel_port_decode_and_mode.sv */
// Self-checking bench for the port decode block, APB master plus printer model.
// Assumes zero-wait APB answers and two-edge pin synchronisers.
`timescale 1ns/10ps
module tb_parallel_port_decode_and_mode;
   import parport_pkg::*;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [12:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, pd_oe, busy, ack_n, paper_out, selected, fault_n, irq;
   logic [6:0]  sw_addr_closed = 7'h21;
   logic        sw_enable_closed = 1, irq_shared_sel = 0, port_bidir_sel = 1, ack_req = 0;
   logic [4:0]  irq_line_header = '0, irq_line_out, irq_line_oe;
   logic [7:0]  pd_in, pd_out, ext_byte = 8'h3C;
   logic [3:0]  ctrl_pins;
   int          err_total = 0, n_compared = 0;
   always #20 clk = ~clk;
   parallel_port_decode_and_mode DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sw_addr_closed, .sw_enable_closed,
      .irq_line_header, .irq_shared_sel, .port_bidir_sel, .pd_in, .pd_out, .pd_oe, .busy,
      .ack_n, .paper_out, .selected, .fault_n, .ctrl_pins, .irq_line_out, .irq_line_oe, .irq);
   printer_model printer (.clk, .pd_out, .pd_oe, .ext_byte, .ack_req, .pd_in, .ack_n,
      .busy, .paper_out, .selected, .fault_n);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Answer is taken at the rising edge where pready is seen high
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(negedge clk);
   endtask
   task automatic wrc(input logic [12:0] a, input logic [31:0] d, input logic e);
      apb(1, a, d);
      chk(er, e);
   endtask
   task automatic rdv(input logic [12:0] a, input logic [31:0] x, input logic e);
      apb(0, a, 0);
      chk(rd, x);
      chk(er, e);
   endtask
   function automatic logic [12:0] io(input logic [9:0] a);
      return {1'b0, a, 2'b00};
   endfunction
   task automatic t_reset;
      chk(pd_oe, 1);
      chk(pd_out, DATA_RST);
      chk(irq_line_oe, 0);
      $display("test reset done");
   endtask
   task automatic t_decode;
      wrc(io(10'h378), 8'hA5, 0);
      chk(pd_out, 8'hA5);
      rdv(io(10'h378), 8'hA5, 0);
      rdv(io(10'h37B), 0, 0);
      rdv(io(10'h37C), 0, 1);
      rdv(io(10'h178), 0, 1);
      @(posedge clk);
      sw_addr_closed <= 7'h61;
      wait_n(4);
      rdv(io(10'h378), 0, 1);
      rdv(io(10'h278), 8'hA5, 0);
      // Disabling the port with the interrupt header already empty
      @(posedge clk);
      sw_enable_closed <= 0;
      wait_n(4);
      wrc(io(10'h278), 8'h11, 1);
      chk(irq_line_oe, 0);
      chk(pd_out, 8'hA5);
      @(posedge clk);
      sw_enable_closed <= 1;
      sw_addr_closed <= 7'h21;
      wait_n(4);
      $display("test decode done");
   endtask
   task automatic t_dir;
      wrc(io(10'h37A), 8'hFF, 0);
      wait_n(2);
      chk(pd_oe, 0);
      chk(ctrl_pins, 4'hF);
      rdv(io(10'h37A), 8'h3F, 0);
      rdv(io(10'h378), 8'h3C, 0);
      apb(0, io(10'h37A), 0);
      apb(1, io(10'h37A), rd & 32'hDF);
      wait_n(2);
      chk(pd_oe, 1);
      @(posedge clk);
      port_bidir_sel <= 0;
      wait_n(4);
      wrc(io(10'h37A), 8'h20, 0);
      wait_n(2);
      chk(pd_oe, 1);
      wrc(io(10'h378), 8'h5A, 0);
      rdv(io(10'h378), 8'h5A, 0);
      $display("test direction done");
   endtask
   task automatic t_irq;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         irq_line_header <= 5'(1 << i);
         wait_n(4);
         chk(irq_line_oe, 32'(1 << i));
      end
      wrc(OWN_IRQ_MASK, 1, 0);
      wrc(io(10'h37A), 8'h10, 0);
      @(posedge clk);
      ack_req <= 1;
      wait_n(6);
      chk(irq, 1);
      chk(irq_line_out, 5'h10);
      rdv(io(10'h379), 8'h1C, 0);
      // Acknowledge still low: a level must not raise it again
      wrc(OWN_IRQ_STATUS, 1, 0);
      wait_n(3);
      chk(irq, 0);
      @(posedge clk);
      ack_req <= 0;
      irq_shared_sel <= 1;
      wait_n(4);
      chk(irq_line_oe, 0);
      @(posedge clk);
      ack_req <= 1;
      wait_n(6);
      chk(irq_line_oe, 5'h10);
      chk(irq_line_out, 5'h10);
      wrc(OWN_IRQ_MASK, 0, 0);
      wait_n(2);
      chk(irq, 0);
      rdv(OWN_IRQ_STATUS, 1, 0);
      $display("test interrupt done");
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      wait_n(3);
      t_reset;
      t_decode;
      t_dir;
      t_irq;
      tally_and_finish;
   end
   // Whole run is about 140 cycles; the 5000-cycle limit is ample
   initial begin
      #200000;
      err_total++;
      tally_and_finish;
   end
endmodule
